// [hdl/pwm8_timer.sv]
`timescale 1ns/100ps
// Summary of operation
// - modes 3 and 7 run single-slope fast PWM
// - fast top is 0xff or compare A
// - fast output clears on match, sets bottom
// - fast counter clears tick after top; bottom action
// - fast overflow flag set at top
// - action two non-inverted, three inverted PWM
// - action one toggles A only with mode msb
// - fast frequency is clock over N times 256
// - fast extremes give spike or constant level
// - fast toggle gives 50% duty, buffered compare
// - modes 1 and 5 run dual-slope PWM
// - phase top is 0xff or compare A
// - phase output clears up-match, sets down-match
// - phase reverses at top, holds no tick
// - phase overflow flag set at bottom
// - phase frequency is clock over N times 510
// - phase extremes give constant low or high
// - leaving top, output takes up-count result unless compare equals top
// - missed up-count match still changes output
// - synchronous, advances only on timer tick
// - action zero does nothing on matches
`include "pwm8_defines.svh"

module pwm8_timer #(
  parameter int COUNT_WIDTH = 8
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CE,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             COMPARE_OUT_A,
  output logic             COMPARE_OUT_B,
  output logic             COMPARE_EN_A,
  output logic             COMPARE_EN_B
);

  if (COUNT_WIDTH != 8) begin : g_width_check
    $error("pwm8_timer serves only an 8-bit counter");
  end

  // configuration and counting state
  logic [2:0]              waveform_mode_sel;
  logic [1:0]              output_action_a_sel;
  logic [1:0]              output_action_b_sel;
  logic [2:0]              prescale_sel;
  logic [7:0]              compare_a_buf;
  logic [7:0]              compare_b_buf;
  logic [7:0]              compare_a_value;
  logic [7:0]              compare_b_value;
  logic [7:0]              count_value;
  pwm8_pkg::count_dir_t    dir;
  logic                    compare_output_a;
  logic                    compare_output_b;
  logic                    overflow_flag;
  logic                    match_flag_a;
  logic                    match_flag_b;
  logic                    count_written;
  logic [9:0]              prescale_cnt;
  logic                    timer_tick;
  logic                    ack;
  logic [31:0]             rdata;

  logic [2:0]              next_waveform_mode_sel;
  logic [1:0]              next_output_action_a_sel;
  logic [1:0]              next_output_action_b_sel;
  logic [2:0]              next_prescale_sel;
  logic [7:0]              next_compare_a_buf;
  logic [7:0]              next_compare_b_buf;
  logic [7:0]              next_compare_a_value;
  logic [7:0]              next_compare_b_value;
  logic [7:0]              next_count_value;
  pwm8_pkg::count_dir_t    next_dir;
  logic                    next_compare_output_a;
  logic                    next_compare_output_b;
  logic                    next_overflow_flag;
  logic                    next_match_flag_a;
  logic                    next_match_flag_b;
  logic                    next_count_written;
  logic [9:0]              next_prescale_cnt;
  logic                    next_timer_tick;
  logic                    next_ack;
  logic [31:0]             next_rdata;

  // mode decode, used for the counter and both channels
  function automatic pwm8_pkg::wave_kind_t wave_kind(input logic [2:0] mode);
    if (mode == `MODE_FAST_FULL || mode == `MODE_FAST_CMPA) begin
      return pwm8_pkg::WAVE_FAST;
    end else if (mode == `MODE_PC_FULL || mode == `MODE_PC_CMPA) begin
      return pwm8_pkg::WAVE_PHASE;
    end
    return pwm8_pkg::WAVE_OTHER;
  endfunction

  // output state after a compare event, shared by both channels
  function automatic logic match_result(input logic [1:0] act, input logic cur, input logic up,
                                        input logic toggle_ok);
    unique case (act)
      `ACT_NONE:   return cur;
      `ACT_TOGGLE: return toggle_ok ? ~cur : cur;
      `ACT_NONINV: return ~up;
      `ACT_INV:    return up;
    endcase
  endfunction

  pwm8_pkg::wave_kind_t kind;
  logic [7:0]           top;
  logic                 at_top;
  logic                 at_bottom;
  logic                 wr;
  logic                 rd;
  logic                 lane0;
  logic                 toggle_ok;

  // mode, top and bus decode; top follows the active compare value, never the buffer
  always_comb begin
    kind      = wave_kind(waveform_mode_sel);
    top       = waveform_mode_sel[2] ? compare_a_value : `COUNT_MAX;
    at_top    = (count_value == top);
    at_bottom = (count_value == `COUNT_BOTTOM);
    wr        = CYC_I && STB_I && WE_I && !ack;
    rd        = CYC_I && STB_I && !WE_I && !ack;
    lane0     = SEL_I[0];
    toggle_ok = waveform_mode_sel[2];
  end

  // prescaler: one-cycle tick enable at the selected division
  // the divider runs free, so after a change of division the first period may be short
  always_comb begin
    next_prescale_cnt = prescale_cnt + 10'h001;
    next_timer_tick   = 1'b0;
    unique case (prescale_sel)
      `PS_DIV1:    next_timer_tick = 1'b1;
      `PS_DIV8:    next_timer_tick = (prescale_cnt[2:0] == `DIV8_LAST);
      `PS_DIV64:   next_timer_tick = (prescale_cnt[5:0] == `DIV64_LAST);
      `PS_DIV256:  next_timer_tick = (prescale_cnt[7:0] == `DIV256_LAST);
      `PS_DIV1024: next_timer_tick = (prescale_cnt == `DIV1024_LAST);
      default:     next_timer_tick = 1'b0;
    endcase
  end

  // counter, buffers, outputs and flags
  always_comb begin
    logic pc_match_a;
    logic pc_match_b;
    logic up;
    logic slope_up;
    pc_match_a                = 1'b0;
    pc_match_b                = 1'b0;
    up                        = (dir == pwm8_pkg::DIR_UP);
    slope_up                  = 1'b1;
    next_waveform_mode_sel    = waveform_mode_sel;
    next_output_action_a_sel  = output_action_a_sel;
    next_output_action_b_sel  = output_action_b_sel;
    next_prescale_sel         = prescale_sel;
    next_compare_a_buf        = compare_a_buf;
    next_compare_b_buf        = compare_b_buf;
    next_compare_a_value      = compare_a_value;
    next_compare_b_value      = compare_b_value;
    next_count_value          = count_value;
    next_dir                  = dir;
    next_compare_output_a     = compare_output_a;
    next_compare_output_b     = compare_output_b;
    next_overflow_flag        = overflow_flag;
    next_match_flag_a         = match_flag_a;
    next_match_flag_b         = match_flag_b;
    // a count write blocks compare matches until one tick has passed
    next_count_written        = count_written && !timer_tick;

    // software clears come first so a same-cycle hardware set wins
    if (wr && lane0 && ADR_I == `ADDR_STATUS) begin
      if (DAT_I[`STAT_OVF])     next_overflow_flag = 1'b0;
      if (DAT_I[`STAT_MATCH_A]) next_match_flag_a  = 1'b0;
      if (DAT_I[`STAT_MATCH_B]) next_match_flag_b  = 1'b0;
    end

    // nothing moves between ticks; the bus side still answers every cycle
    if (timer_tick) begin
      if (kind == pwm8_pkg::WAVE_FAST) begin
        // the top tick both clears the counter and reloads the compares
        if (at_top) begin
          next_count_value     = `COUNT_BOTTOM;
          next_compare_a_value = compare_a_buf;
          next_compare_b_value = compare_b_buf;
        end else begin
          next_count_value = count_value + 8'h01;
        end
        next_dir = pwm8_pkg::DIR_UP;
        if (at_top) begin
          next_overflow_flag = 1'b1;
          // bottom action on the tick that clears the counter; a set or clear match at top is ignored
          // the bottom level is the opposite of what a match gives
          if (output_action_a_sel[1]) next_compare_output_a = ~output_action_a_sel[0];
          if (output_action_b_sel[1]) next_compare_output_b = ~output_action_b_sel[0];
        end
        // a toggle still acts at top; only set or clear waits for bottom
        if (count_value == compare_a_value && !count_written) begin
          if (!(at_top && output_action_a_sel[1]))
            next_compare_output_a = match_result(output_action_a_sel, compare_output_a, 1'b1, toggle_ok);
        end
        if (count_value == compare_b_value && !count_written && !at_top)
          next_compare_output_b = match_result(output_action_b_sel, compare_output_b, 1'b1, 1'b0);
      end else if (kind == pwm8_pkg::WAVE_PHASE) begin
        if (up) begin
          if (at_top) begin
            next_dir             = pwm8_pkg::DIR_DOWN;
            // a top of zero holds the count at zero instead of wrapping to max
            if (!at_bottom) next_count_value = count_value - 8'h01;
            // the down-slope and the next up-slope use the same compare value
            next_compare_a_value = compare_a_buf;
            next_compare_b_value = compare_b_buf;
          end else begin
            next_count_value = count_value + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            next_dir         = pwm8_pkg::DIR_UP;
            if (!at_top) next_count_value = count_value + 8'h01;
          end else begin
            next_count_value = count_value - 8'h01;
          end
        end
        if (next_count_value == `COUNT_BOTTOM) next_overflow_flag = 1'b1;
        pc_match_a = (count_value == compare_a_value) && !count_written;
        pc_match_b = (count_value == compare_b_value) && !count_written;
        // bottom is passed once, while the direction still reads down, yet it opens
        // the up-slope: a match there gives the up-count result
        slope_up   = up || at_bottom;
        // at top the set or clear follows the up-count result, or the down-count result when compare equals top;
        // this also makes good an up-count match skipped by a count loaded above compare
        if (at_top && up) begin
          if (output_action_a_sel[1]) next_compare_output_a = ~output_action_a_sel[0] ^ ~pc_match_a;
          if (output_action_b_sel[1]) next_compare_output_b = ~output_action_b_sel[0] ^ ~pc_match_b;
          if (output_action_a_sel == `ACT_TOGGLE && pc_match_a)
            next_compare_output_a = match_result(output_action_a_sel, compare_output_a, up, toggle_ok);
        end else begin
          if (pc_match_a)
            next_compare_output_a = match_result(output_action_a_sel, compare_output_a, slope_up, toggle_ok);
          if (pc_match_b)
            next_compare_output_b = match_result(output_action_b_sel, compare_output_b, slope_up, 1'b0);
        end
      end else begin
        // other modes only count here, so software still sees a running timer
        next_count_value = count_value + 8'h01;
        next_dir         = pwm8_pkg::DIR_UP;
        if (at_top) next_overflow_flag = 1'b1;
        next_compare_a_value = compare_a_buf;
        next_compare_b_value = compare_b_buf;
      end
      // match flags follow the raw compare in every mode
      if (count_value == compare_a_value && !count_written) next_match_flag_a = 1'b1;
      if (count_value == compare_b_value && !count_written) next_match_flag_b = 1'b1;
    end

    // register writes; low byte lane only
    if (wr && lane0) begin
      unique case (ADR_I)
        `ADDR_CTRL: begin
          next_waveform_mode_sel   = DAT_I[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          next_output_action_b_sel = DAT_I[`CTRL_ACT_B_MSB:`CTRL_ACT_B_LSB];
          next_output_action_a_sel = DAT_I[`CTRL_ACT_A_MSB:`CTRL_ACT_A_LSB];
        end
        `ADDR_CMP_A: begin
          // in PWM modes the write waits in the buffer for top
          next_compare_a_buf = DAT_I[7:0];
          if (kind == pwm8_pkg::WAVE_OTHER) next_compare_a_value = DAT_I[7:0];
        end
        `ADDR_CMP_B: begin
          next_compare_b_buf = DAT_I[7:0];
          if (kind == pwm8_pkg::WAVE_OTHER) next_compare_b_value = DAT_I[7:0];
        end
        `ADDR_COUNT: begin
          next_count_value   = DAT_I[7:0]; // blocks a match on the next tick
          next_count_written = 1'b1;
        end
        `ADDR_PRESCALE: next_prescale_sel = DAT_I[2:0];
        default: ;
      endcase
    end
  end

  // wishbone slave: one-cycle ack, unmapped reads return zero
  // ack is withheld the cycle after it is given, so a strobe held one cycle past ack is taken a second time
  always_comb begin
    next_ack   = CYC_I && STB_I && !ack;
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (ADR_I)
        `ADDR_CTRL:     next_rdata[7:0] = {output_action_a_sel, output_action_b_sel, 1'b0, waveform_mode_sel};
        `ADDR_CMP_A:    next_rdata[7:0] = compare_a_buf;
        `ADDR_CMP_B:    next_rdata[7:0] = compare_b_buf;
        `ADDR_COUNT:    next_rdata[7:0] = count_value;
        `ADDR_STATUS:   next_rdata[2:0] = {match_flag_b, match_flag_a, overflow_flag};
        `ADDR_PRESCALE: next_rdata[2:0] = prescale_sel;
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // all state registers, frozen while CE is low
  always_ff @(posedge CLK) begin
    // reset does not wait for CE, so the block always comes up clean
    if (SRST) begin
      waveform_mode_sel   <= 3'h0;
      output_action_a_sel <= `ACT_NONE;
      output_action_b_sel <= `ACT_NONE;
      prescale_sel        <= `PS_OFF;
      compare_a_buf       <= 8'h00;
      compare_b_buf       <= 8'h00;
      compare_a_value     <= 8'h00;
      compare_b_value     <= 8'h00;
      count_value         <= `COUNT_BOTTOM;
      dir                 <= pwm8_pkg::DIR_UP;
      compare_output_a    <= 1'b0;
      compare_output_b    <= 1'b0;
      overflow_flag       <= 1'b0;
      match_flag_a        <= 1'b0;
      match_flag_b        <= 1'b0;
      count_written       <= 1'b0;
      prescale_cnt        <= 10'h000;
      timer_tick          <= 1'b0;
      ack                 <= 1'b0;
      rdata               <= 32'h0000_0000;
      COMPARE_OUT_A       <= 1'b0;
      COMPARE_OUT_B       <= 1'b0;
      COMPARE_EN_A        <= 1'b0;
      COMPARE_EN_B        <= 1'b0;
    end else if (CE) begin
      waveform_mode_sel   <= next_waveform_mode_sel;
      output_action_a_sel <= next_output_action_a_sel;
      output_action_b_sel <= next_output_action_b_sel;
      prescale_sel        <= next_prescale_sel;
      compare_a_buf       <= next_compare_a_buf;
      compare_b_buf       <= next_compare_b_buf;
      compare_a_value     <= next_compare_a_value;
      compare_b_value     <= next_compare_b_value;
      count_value         <= next_count_value;
      dir                 <= next_dir;
      compare_output_a    <= next_compare_output_a;
      compare_output_b    <= next_compare_output_b;
      overflow_flag       <= next_overflow_flag;
      match_flag_a        <= next_match_flag_a;
      match_flag_b        <= next_match_flag_b;
      count_written       <= next_count_written;
      prescale_cnt        <= next_prescale_cnt;
      timer_tick          <= next_timer_tick;
      ack                 <= next_ack;
      rdata               <= next_rdata;
      // pin copies lag the internal register by one cycle
      COMPARE_OUT_A       <= compare_output_a;
      COMPARE_OUT_B       <= compare_output_b;
      // a reserved toggle code leaves the pin undriven
      COMPARE_EN_A        <= (output_action_a_sel != `ACT_NONE) &&
                             !(output_action_a_sel == `ACT_TOGGLE && kind != pwm8_pkg::WAVE_OTHER && !toggle_ok);
      COMPARE_EN_B        <= (output_action_b_sel != `ACT_NONE) &&
                             !(output_action_b_sel == `ACT_TOGGLE && kind != pwm8_pkg::WAVE_OTHER);
    end
  end

  // bus outputs come straight from their registers
  assign DAT_O = rdata;
  assign ACK_O = ack;

endmodule

// [common/pwm8_defines.svh]
`ifndef PWM8_DEFINES_SVH
`define PWM8_DEFINES_SVH

// register byte addresses (word aligned)
`define ADDR_CTRL      8'h00
`define ADDR_CMP_A     8'h04
`define ADDR_CMP_B     8'h08
`define ADDR_COUNT     8'h0c
`define ADDR_STATUS    8'h10
`define ADDR_PRESCALE  8'h14

// control register fields
`define CTRL_MODE_LSB  0
`define CTRL_MODE_MSB  2
`define CTRL_ACT_B_LSB 4
`define CTRL_ACT_B_MSB 5
`define CTRL_ACT_A_LSB 6
`define CTRL_ACT_A_MSB 7

// status register fields, write one to clear
`define STAT_OVF       0
`define STAT_MATCH_A   1
`define STAT_MATCH_B   2

// waveform mode codes
`define MODE_PC_FULL   3'h1
`define MODE_FAST_FULL 3'h3
`define MODE_PC_CMPA   3'h5
`define MODE_FAST_CMPA 3'h7

// output action codes
`define ACT_NONE       2'h0
`define ACT_TOGGLE     2'h1
`define ACT_NONINV     2'h2
`define ACT_INV        2'h3

// prescale select codes and counter limits
`define PS_OFF         3'h0
`define PS_DIV1        3'h1
`define PS_DIV8        3'h2
`define PS_DIV64       3'h3
`define PS_DIV256      3'h4
`define PS_DIV1024     3'h5
`define DIV8_LAST      3'h7
`define DIV64_LAST     6'h3f
`define DIV256_LAST    8'hff
`define DIV1024_LAST   10'h3ff

`define COUNT_BOTTOM   8'h00
`define COUNT_MAX      8'hff

`endif

// [common/pwm8_pkg.sv]
package pwm8_pkg;
  typedef enum logic [1:0] {WAVE_OTHER, WAVE_FAST, WAVE_PHASE} wave_kind_t;
  typedef enum {DIR_UP, DIR_DOWN} count_dir_t;
endpackage

// [test/pwm8_load_model.sv]
`timescale 1ns/100ps
module pwm8_load_model (
  input  wire logic        clk,
  input  wire logic        clear,
  input  wire logic        pin,
  input  wire logic        en,
  output logic      [15:0] period,
  output logic      [15:0] high_cnt,
  output logic      [7:0]  rises,
  output logic             level
);
  logic        prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  // the load only sees the pin while the timer drives it
  assign level = en & pin;
  // rise-to-rise period and high time; first latch after clear is junk
  always @(posedge clk) begin
    prev <= level;
    if (clear) begin
      cnt <= 16'h0000;
      hcnt <= 16'h0000;
      rises <= 8'h00;
    end else if (level && !prev) begin
      period <= cnt;
      high_cnt <= hcnt;
      cnt <= 16'h0001;
      hcnt <= 16'h0001;
      rises <= rises + 8'h01;
    end else begin
      cnt <= cnt + 16'h0001;
      hcnt <= hcnt + {15'h0000, level};
    end
  end
endmodule

// [test/pwm8_timer_props.sv]
`timescale 1ns/100ps
`include "pwm8_defines.svh"
module pwm8_timer_props (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        CE,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        COMPARE_OUT_A,
  input wire logic        COMPARE_OUT_B,
  input wire logic        COMPARE_EN_A,
  input wire logic        COMPARE_EN_B
);
  logic [7:0] ctrl_sh;
  logic [7:0] next_ctrl_sh;
  logic       pwm_mode;
  logic       en_a_exp;
  logic       en_b_exp;
  // shadow of the control byte, taken at the acked write
  always_comb begin
    next_ctrl_sh = ctrl_sh;
    if (ACK_O && CYC_I && STB_I && WE_I && SEL_I[0] && ADR_I == `ADDR_CTRL)
      next_ctrl_sh = DAT_I[7:0];
  end
  always_ff @(posedge CLK) begin
    if (SRST)
      ctrl_sh <= 8'h00;
    else
      ctrl_sh <= next_ctrl_sh;
  end
  // toggle on A needs the mode msb; toggle on B is reserved
  assign pwm_mode = ctrl_sh[0];
  assign en_a_exp = ctrl_sh[7:6] != 2'h0 && !(ctrl_sh[7:6] == 2'h1 && !ctrl_sh[2]);
  assign en_b_exp = ctrl_sh[5:4] != 2'h0 && ctrl_sh[5:4] != 2'h1;

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
  a_ack_follows: assert property (CE && CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("request not acked");
  a_ack_caused: assert property (ACK_O |-> $past(CYC_I && STB_I && CE)) else $error("ack without request");
  a_data_idle: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data outside ack");
  a_data_byte: assert property (ACK_O |-> DAT_O[31:8] == 24'h0) else $error("upper read bits set");
  a_ce_freeze:
    assert property ($past(!CE) && $past(!CE, 2) |-> $stable(COMPARE_OUT_A) && $stable(COMPARE_OUT_B))
    else $error("pins moved without enable");
  a_reset_quiet: assert property ($fell(SRST) |-> !COMPARE_EN_A && !COMPARE_EN_B && !COMPARE_OUT_A)
    else $error("pins active after reset");
  a_enable_a:
    assert property (pwm_mode && $stable(ctrl_sh) |-> COMPARE_EN_A == en_a_exp) else $error("pin a enable wrong");
  a_enable_b:
    assert property (pwm_mode && $stable(ctrl_sh) |-> COMPARE_EN_B == en_b_exp) else $error("pin b enable wrong");

  c_write: cover property (ACK_O && WE_I);
  c_read: cover property (ACK_O && !WE_I);
  c_rise_a: cover property ($rose(COMPARE_OUT_A));
  c_en_b: cover property ($rose(COMPARE_EN_B));
endmodule

bind pwm8_timer pwm8_timer_props chk_u (.CLK, .SRST, .CE, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I,
  .DAT_O, .ACK_O, .COMPARE_OUT_A, .COMPARE_OUT_B, .COMPARE_EN_A, .COMPARE_EN_B);

// [test/pwm8_timer_tb_top.sv]
`timescale 1ns/100ps
`include "pwm8_defines.svh"
module pwm8_timer_tb_top;
  logic        clk;
  logic        srst;
  logic        ce;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        out_a;
  logic        out_b;
  logic        en_a;
  logic        en_b;
  logic        clr;
  logic [15:0] per_a, per_b, hi_a, hi_b;
  logic [7:0]  rise_a, rise_b;
  logic        lvl_a, lvl_b;
  int          mismatches;
  int          check_count;

  pwm8_timer dut_u (.CLK(clk), .SRST(srst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .COMPARE_OUT_A(out_a), .COMPARE_OUT_B(out_b),
    .COMPARE_EN_A(en_a), .COMPARE_EN_B(en_b));
  pwm8_load_model load_a (.clk(clk), .clear(clr), .pin(out_a), .en(en_a), .period(per_a), .high_cnt(hi_a),
    .rises(rise_a), .level(lvl_a));
  pwm8_load_model load_b (.clk(clk), .clear(clr), .pin(out_b), .en(en_b), .period(per_b), .high_cnt(hi_b),
    .rises(rise_b), .level(lvl_b));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        complete_run();
      end
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
  endtask

  function automatic logic [7:0] cfg(input logic [2:0] m, input logic [1:0] a, input logic [1:0] b);
    return {a, b, 1'b0, m};
  endfunction

  // settle, restart the loads, then observe for the same span
  task automatic setup(input logic [2:0] ps, input logic [7:0] c, input logic [7:0] ca, input logic [7:0] cb,
                       input int settle);
    logic [31:0] q;
    wb(1'b1, `ADDR_PRESCALE, {5'h00, ps}, q);
    wb(1'b1, `ADDR_CTRL, c, q);
    wb(1'b1, `ADDR_CMP_A, ca, q);
    wb(1'b1, `ADDR_CMP_B, cb, q);
    repeat (settle) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (settle) @(posedge clk);
  endtask

  // zero period means a constant level equal to the high figure
  task automatic wave(input logic [15:0] pa, input logic [15:0] ha, input logic [15:0] pb, input logic [15:0] hb);
    if (pa == 16'h0000) begin
      check({24'h0, rise_a}, 32'h0);
      check({31'h0, lvl_a}, {16'h0, ha});
    end else begin
      check({16'h0, per_a}, {16'h0, pa});
      check({16'h0, hi_a}, {16'h0, ha});
    end
    if (pb == 16'h0000) begin
      check({24'h0, rise_b}, 32'h0);
      check({31'h0, lvl_b}, {16'h0, hb});
    end else begin
      check({16'h0, per_b}, {16'h0, pb});
      check({16'h0, hi_b}, {16'h0, hb});
    end
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, `ADDR_CTRL, 8'h00, q);
    check(q, 32'h0);
    wb(1'b1, 8'h1c, 8'h5a, q);
    wb(1'b0, 8'h1c, 8'h00, q);
    check(q, 32'h0);
    check({31'h0, en_a}, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_waves();
    setup(`PS_DIV1, cfg(`MODE_FAST_FULL, `ACT_NONINV, `ACT_INV), 8'h3f, 8'h3f, 600);
    wave(16'd256, 16'd64, 16'd256, 16'd192);
    setup(`PS_DIV1, cfg(`MODE_FAST_FULL, `ACT_NONINV, `ACT_NONINV), 8'h00, 8'hff, 600);
    wave(16'd256, 16'd1, 16'd0, 16'd1);
    setup(`PS_DIV1, cfg(`MODE_PC_FULL, `ACT_NONINV, `ACT_NONINV), 8'h00, 8'hff, 1100);
    wave(16'd0, 16'd0, 16'd0, 16'd1);
    setup(`PS_DIV1, cfg(`MODE_PC_FULL, `ACT_NONINV, `ACT_INV), 8'h3f, 8'h3f, 1100);
    wave(16'd510, 16'd126, 16'd510, 16'd384);
    setup(`PS_DIV8, cfg(`MODE_FAST_FULL, `ACT_NONINV, `ACT_NONE), 8'h3f, 8'h00, 4500);
    wave(16'd2048, 16'd512, 16'd0, 16'd0);
    $display("t_waves done");
  endtask

  task automatic t_toggle();
    setup(`PS_DIV1, cfg(`MODE_FAST_CMPA, `ACT_TOGGLE, `ACT_TOGGLE), 8'h03, 8'h00, 300);
    wave(16'd8, 16'd4, 16'd0, 16'd0);
    check({31'h0, en_b}, 32'h0);
    setup(`PS_DIV1, cfg(`MODE_PC_CMPA, `ACT_TOGGLE, `ACT_NONE), 8'h03, 8'h00, 100);
    wave(16'd12, 16'd6, 16'd0, 16'd0);
    setup(`PS_DIV1, cfg(`MODE_FAST_FULL, `ACT_TOGGLE, `ACT_NONE), 8'h03, 8'h00, 20);
    check({31'h0, en_a}, 32'h0);
    $display("t_toggle done");
  endtask

  // overflow flag with the prescaler stopped, then running; enable dropped meanwhile
  task automatic t_flag();
    logic [31:0] q;
    setup(`PS_OFF, cfg(`MODE_FAST_FULL, `ACT_NONINV, `ACT_NONE), 8'h3f, 8'h00, 10);
    wb(1'b1, `ADDR_STATUS, 8'h07, q);
    wb(1'b0, `ADDR_STATUS, 8'h00, q);
    check({31'h0, q[`STAT_OVF]}, 32'h0);
    wb(1'b1, `ADDR_PRESCALE, {5'h00, `PS_DIV1}, q);
    repeat (300) @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wb(1'b0, `ADDR_STATUS, 8'h00, q);
    check({31'h0, q[`STAT_OVF]}, 32'h1);
    wb(1'b1, `ADDR_CTRL, cfg(`MODE_PC_FULL, `ACT_NONINV, `ACT_NONE), q);
    wb(1'b1, `ADDR_STATUS, 8'h07, q);
    repeat (600) @(posedge clk);
    wb(1'b0, `ADDR_STATUS, 8'h00, q);
    check({31'h0, q[`STAT_OVF]}, 32'h1);
    $display("t_flag done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    mismatches = 0;
    check_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    clr = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    clr <= 1'b0;
    t_regs();
    t_waves();
    t_toggle();
    t_flag();
    complete_run();
  end
endmodule
